// *** mmc_regs.vh ***
// Address map, reset values and timing constants of the memory map controller
`ifndef MMC_REGS_VH
`define MMC_REGS_VH

// Register port offsets
`define MMC_OFS_MODE          4'h0
`define MMC_OFS_PAGE          4'h1
`define MMC_OFS_DBG_PAGE      4'h2
`define MMC_OFS_STATUS        4'h3

// Reset values
`define MMC_PAGE_RESET        4'hE
`define MMC_DBG_PAGE_RESET    4'h0

// Fixed pages behind the unpaged local ranges
`define MMC_PAGE_FIXED_LOW    4'hC
`define MMC_PAGE_FIXED_MID    4'hD
`define MMC_PAGE_FIXED_TOP    4'hF
`define MMC_PAGE_DEBUG_ALIAS  4'hF

// Local map windows (top address bits)
`define MMC_LOC_WIN_LOW       2'b00
`define MMC_LOC_WIN_MID       2'b01
`define MMC_LOC_WIN_PAGED     2'b10
`define MMC_LOC_WIN_TOP       2'b11
`define MMC_LOC_DEBUG_HI      8'hFF
`define MMC_LOC_DEBUG_ALIAS   8'hBF

// Global map, 18 address bits
`define MMC_GLB_REG_TOP       18'h0_03FF
`define MMC_GLB_RAM_END       18'h0_4000
`define MMC_GLB_DFL_BOT       18'h0_4400
`define MMC_GLB_DFL_TOP       18'h0_53FF
`define MMC_GLB_PFL_END       19'h4_0000

// Default sizes
`define MMC_RAM_SIZE_DEF      18'h0_1800
`define MMC_FLASH_SIZE_DEF    19'h2_0000

// Target select codes
`define MMC_TGT_NONE          3'h0
`define MMC_TGT_REG           3'h1
`define MMC_TGT_RAM           3'h2
`define MMC_TGT_DFL           3'h3
`define MMC_TGT_PFL           3'h4
`define MMC_TGT_DEBUG         3'h5

// Debug starvation limit in cycles
`define MMC_DBG_STALL_LIMIT   8'h80

`endif

// *** mmc_decode.v ***
// Global address decoder: picks the target behind an 18-bit global address
`timescale 1ns/1ps
`default_nettype none
`include "mmc_regs.vh"

module mmc_decode #(
  parameter [17:0] RAM_SIZE   = `MMC_RAM_SIZE_DEF,
  parameter [18:0] FLASH_SIZE = `MMC_FLASH_SIZE_DEF
) (
  input  wire [17:0] i_glb_addr,
  input  wire        i_debug_sel,
  output reg  [2:0]  o_target
);

  wire [18:0] glb_ext  = {1'b0, i_glb_addr};
  wire [17:0] ram_low  = `MMC_GLB_RAM_END - RAM_SIZE;
  wire [18:0] pfl_low  = `MMC_GLB_PFL_END - FLASH_SIZE;

  always @* begin
    if (i_debug_sel) begin
      o_target = `MMC_TGT_DEBUG;
    end else if (i_glb_addr <= `MMC_GLB_REG_TOP) begin
      o_target = `MMC_TGT_REG;
    end else if (i_glb_addr >= ram_low && i_glb_addr < `MMC_GLB_RAM_END) begin
      o_target = `MMC_TGT_RAM;
    end else if (i_glb_addr >= `MMC_GLB_DFL_BOT && i_glb_addr <= `MMC_GLB_DFL_TOP) begin
      o_target = `MMC_TGT_DFL;
    end else if (glb_ext >= pfl_low) begin
      o_target = `MMC_TGT_PFL;
    end else begin
      o_target = `MMC_TGT_NONE;
    end
  end

endmodule // mmc_decode
`default_nettype wire

// *** mcu_memory_map_controller.v ***
// Memory map controller: mode, paging, global decode, illegal access reset, arbitration
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "mmc_regs.vh"

module mcu_memory_map_controller #(
  parameter [17:0] RAM_SIZE   = `MMC_RAM_SIZE_DEF,
  parameter [18:0] FLASH_SIZE = `MMC_FLASH_SIZE_DEF
) (
  input  wire        i_sys_clk,
  input  wire        i_rst_b,
  // Operating mode pin, captured after reset release
  input  wire        i_operating_mode_select,
  input  wire        i_debug_exit,
  // Register port
  input  wire [3:0]  i_reg_addr,
  input  wire [7:0]  i_reg_wdata,
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  output reg  [7:0]  o_reg_rdata,
  // CPU master
  input  wire        i_cpu_req,
  input  wire        i_cpu_we,
  input  wire        i_cpu_word,
  input  wire [15:0] i_cpu_addr,
  input  wire [15:0] i_cpu_wdata,
  input  wire        i_cpu_op_end,
  input  wire        i_cpu_page_wr,
  input  wire [3:0]  i_cpu_page_wdata,
  output wire        o_cpu_grant,
  output reg  [15:0] o_cpu_rdata,
  output wire [3:0]  o_cpu_page,
  // Debug master
  input  wire        i_dbg_req,
  input  wire        i_dbg_we,
  input  wire [15:0] i_dbg_addr,
  input  wire [15:0] i_dbg_wdata,
  input  wire        i_dbg_cycle,
  input  wire        i_dbg_page_en,
  input  wire        i_dbg_cmd_uses_page,
  output wire        o_dbg_grant,
  output reg  [15:0] o_dbg_rdata,
  // Target bus
  output reg  [17:0] o_tgt_addr,
  output reg  [15:0] o_tgt_wdata,
  output reg         o_tgt_we,
  output reg         o_tgt_word,
  output reg  [2:0]  o_tgt_sel,
  input  wire [15:0] i_tgt_rdata,
  // System status
  output wire        o_background_debug_mode,
  output wire        o_special_mode,
  output reg         o_illegal_reset,
  output wire        o_ext_bus_en,
  output wire        o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser
  reg [1:0] rst_sync_r;
  wire      rst_b = rst_sync_r[1];

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode pin synchroniser: level captured once, when stages 2 and 3 first agree
  reg [2:0] mode_pin_r;
  reg [2:0] mode_vld_r;
  reg       mode_captured_r;
  reg       special_mode_r;
  reg       dbg_active_r;

  // The valid chain keeps the reset zeros of the pin chain from posing as a low pin
  always @(posedge i_sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_pin_r <= 3'b000;
      mode_vld_r <= 3'b000;
    end else begin
      mode_pin_r <= {mode_pin_r[1:0], i_operating_mode_select};
      mode_vld_r <= {mode_vld_r[1:0], 1'b1};
    end
  end

  wire mode_pin_stable = mode_vld_r[2] && (mode_pin_r[1] == mode_pin_r[2]);

  // Mode bit high means normal single chip; low means special
  always @(posedge i_sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_captured_r <= 1'b0;
      special_mode_r  <= 1'b0;
      dbg_active_r    <= 1'b0;
    end else begin
      if (!mode_captured_r && mode_pin_stable) begin
        mode_captured_r <= 1'b1;
        special_mode_r  <= ~mode_pin_r[2];
        dbg_active_r    <= ~mode_pin_r[2];
      end else if (i_reg_wr && i_reg_addr == `MMC_OFS_MODE && special_mode_r
                   && i_reg_wdata[7]) begin
        // Only special to normal is permitted; never back
        special_mode_r <= 1'b0;
      end
      if (mode_captured_r && i_debug_exit) begin
        dbg_active_r <= 1'b0;
      end
    end
  end

  assign o_background_debug_mode = dbg_active_r;
  assign o_special_mode          = special_mode_r;
  assign o_ext_bus_en            = 1'b0;
  assign o_irq                   = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Page index registers
  reg [3:0] page_r;
  reg [3:0] dbg_page_r;

  always @(posedge i_sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      page_r     <= `MMC_PAGE_RESET;
      dbg_page_r <= `MMC_DBG_PAGE_RESET;
    end else begin
      // Far call/return write lands the same cycle, well before the instruction ends
      if (i_cpu_page_wr) begin
        page_r <= i_cpu_page_wdata;
      end else if (i_reg_wr && i_reg_addr == `MMC_OFS_PAGE) begin
        page_r <= i_reg_wdata[3:0];
      end
      if (i_reg_wr && i_reg_addr == `MMC_OFS_DBG_PAGE) begin
        dbg_page_r <= i_reg_wdata[3:0];
      end
    end
  end

  assign o_cpu_page = page_r;

  ////////////////////////////////////////////////////////////////////////////
  // Local to global expansion, shared by both masters
  wire [17:0] ram_low = `MMC_GLB_RAM_END - RAM_SIZE;

  function [17:0] expand;
    input [15:0] loc;
    input [3:0]  page;
    reg   [3:0]  pg;
    begin
      case (loc[15:14])
        `MMC_LOC_WIN_LOW:   pg = `MMC_PAGE_FIXED_LOW;
        `MMC_LOC_WIN_MID:   pg = `MMC_PAGE_FIXED_MID;
        `MMC_LOC_WIN_PAGED: pg = page;
        `MMC_LOC_WIN_TOP:   pg = `MMC_PAGE_FIXED_TOP;
        default:            pg = page;
      endcase
      // Registers and RAM cover their part of the low fixed page at their own global spot
      if (loc[15:14] == `MMC_LOC_WIN_LOW &&
          ({4'h0, loc[13:0]} <= `MMC_GLB_REG_TOP || {4'h0, loc[13:0]} >= ram_low)) begin
        expand = {4'h0, loc[13:0]};
      end else begin
        expand = {pg, loc[13:0]};
      end
    end
  endfunction

  // Debug resources visible only in debug cycles while active
  function debug_hit;
    input [15:0] loc;
    input [3:0]  page;
    input        active;
    input        cyc;
    begin
      debug_hit = active && cyc &&
                  (loc[15:8] == `MMC_LOC_DEBUG_HI ||
                   (loc[15:8] == `MMC_LOC_DEBUG_ALIAS &&
                    page == `MMC_PAGE_DEBUG_ALIAS));
    end
  endfunction

  wire [3:0]  dbg_eff_page = (i_dbg_page_en && i_dbg_cmd_uses_page)
                             ? dbg_page_r : page_r;
  wire [17:0] cpu_glb      = expand(i_cpu_addr, page_r);
  wire [17:0] dbg_glb      = expand(i_dbg_addr, dbg_eff_page);
  // Firmware commands run by the CPU in active debug also reach debug space
  wire        cpu_dbg_hit  = debug_hit(i_cpu_addr, page_r, dbg_active_r, i_dbg_cycle);
  wire        dbg_dbg_hit  = debug_hit(i_dbg_addr, page_r, dbg_active_r, i_dbg_cycle);

  wire [2:0]  cpu_tgt;
  wire [2:0]  dbg_tgt;

  mmc_decode #(
    .RAM_SIZE   (RAM_SIZE),
    .FLASH_SIZE (FLASH_SIZE)
  ) u_cpu_dec (
    .i_glb_addr  (cpu_glb),
    .i_debug_sel (cpu_dbg_hit),
    .o_target    (cpu_tgt)
  );

  mmc_decode #(
    .RAM_SIZE   (RAM_SIZE),
    .FLASH_SIZE (FLASH_SIZE)
  ) u_dbg_dec (
    .i_glb_addr  (dbg_glb),
    .i_debug_sel (dbg_dbg_hit),
    .o_target    (dbg_tgt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration: single shared target bus
  reg [7:0] stall_cnt_r;
  reg       dbg_prio_r;

  wire both_req  = i_cpu_req && i_dbg_req;
  wire dbg_wins  = i_dbg_req && (!i_cpu_req || dbg_prio_r);
  assign o_dbg_grant = dbg_wins;
  assign o_cpu_grant = i_cpu_req && !dbg_wins;

  always @(posedge i_sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stall_cnt_r <= 8'h00;
      dbg_prio_r  <= 1'b0;
    end else begin
      if (!i_dbg_req || dbg_wins) begin
        stall_cnt_r <= 8'h00;
      end else if (both_req && stall_cnt_r != `MMC_DBG_STALL_LIMIT) begin
        stall_cnt_r <= stall_cnt_r + 8'h01;
      end
      // Hand over only at the CPU's operation boundary
      if (!i_dbg_req || dbg_wins) begin
        dbg_prio_r <= 1'b0;
      end else if (stall_cnt_r == `MMC_DBG_STALL_LIMIT && i_cpu_op_end) begin
        dbg_prio_r <= 1'b1;
      end
    end
  end

  // Target bus and read data
  reg         cpu_rd_pend_r;
  reg         cpu_rd_word_r;
  reg         cpu_rd_odd_r;
  reg         dbg_rd_pend_r;

  always @(posedge i_sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      o_tgt_addr      <= 18'h0_0000;
      o_tgt_wdata     <= 16'h0000;
      o_tgt_we        <= 1'b0;
      o_tgt_word      <= 1'b0;
      o_tgt_sel       <= `MMC_TGT_NONE;
      o_cpu_rdata     <= 16'h0000;
      o_dbg_rdata     <= 16'h0000;
      o_illegal_reset <= 1'b0;
      cpu_rd_pend_r   <= 1'b0;
      cpu_rd_word_r   <= 1'b0;
      cpu_rd_odd_r    <= 1'b0;
      dbg_rd_pend_r   <= 1'b0;
    end else begin
      o_illegal_reset <= 1'b0;
      cpu_rd_pend_r   <= 1'b0;
      dbg_rd_pend_r   <= 1'b0;
      if (dbg_wins) begin
        o_tgt_addr    <= dbg_glb;
        o_tgt_wdata   <= i_dbg_wdata;
        o_tgt_we      <= i_dbg_we;
        o_tgt_word    <= 1'b1;
        o_tgt_sel     <= dbg_tgt;
        dbg_rd_pend_r <= !i_dbg_we;
      end else if (o_cpu_grant) begin
        o_tgt_addr    <= cpu_glb;
        o_tgt_wdata   <= i_cpu_wdata;
        o_tgt_we      <= i_cpu_we;
        o_tgt_word    <= i_cpu_word;
        o_tgt_sel     <= cpu_tgt;
        cpu_rd_pend_r <= !i_cpu_we;
        cpu_rd_word_r <= i_cpu_word;
        cpu_rd_odd_r  <= i_cpu_addr[0];
        if (cpu_tgt == `MMC_TGT_NONE && !i_dbg_cycle) begin
          o_illegal_reset <= 1'b1;
        end
      end else begin
        o_tgt_sel <= `MMC_TGT_NONE;
        o_tgt_we  <= 1'b0;
      end
      // Targets answer the address once it stands, so read data are taken a cycle later
      if (cpu_rd_pend_r) begin
        // Byte reads from odd addresses come back in the low lane
        o_cpu_rdata <= (!cpu_rd_word_r && cpu_rd_odd_r) ? {8'h00, i_tgt_rdata[7:0]}
                     : (!cpu_rd_word_r) ? {8'h00, i_tgt_rdata[15:8]}
                     : i_tgt_rdata;
      end
      if (dbg_rd_pend_r) begin
        o_dbg_rdata <= i_tgt_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port reads
  always @(posedge i_sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `MMC_OFS_MODE:     o_reg_rdata <= {~special_mode_r, 7'h00};
        `MMC_OFS_PAGE:     o_reg_rdata <= {4'h0, page_r};
        `MMC_OFS_DBG_PAGE: o_reg_rdata <= {4'h0, dbg_page_r};
        `MMC_OFS_STATUS:   o_reg_rdata <= {6'h00, dbg_prio_r, dbg_active_r};
        default:           o_reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule // mcu_memory_map_controller
`default_nettype wire

// *** tgt_model.sv ***
// Target-side responder model: answers every global address with a pattern
`timescale 1ns/1ps
`default_nettype none

module tgt_model (
  input  wire logic [17:0] i_tgt_addr,
  output logic      [15:0] o_tgt_rdata
);
  // Page bits are mixed in so that aliased pages never return the same data
  assign o_tgt_rdata = i_tgt_addr[15:0] ^ {12'hA5A, i_tgt_addr[17:14]};
endmodule // tgt_model

`default_nettype wire

// *** mmc_chk.sv ***
// Port checker for the memory map controller
`timescale 1ns/1ps
`default_nettype none

module mmc_chk #(
  parameter [17:0] RAM_SIZE   = 18'h0_1800,
  parameter [18:0] FLASH_SIZE = 19'h2_0000
) (
  input wire logic        i_sys_clk,
  input wire logic        i_rst_b,
  input wire logic        i_cpu_req,
  input wire logic        i_cpu_op_end,
  input wire logic [15:0] i_cpu_addr,
  input wire logic        i_dbg_req,
  input wire logic        i_dbg_cycle,
  input wire logic [15:0] i_dbg_addr,
  input wire logic        o_cpu_grant,
  input wire logic        o_dbg_grant,
  input wire logic [3:0]  o_cpu_page,
  input wire logic [17:0] o_tgt_addr,
  input wire logic [2:0]  o_tgt_sel,
  input wire logic        o_background_debug_mode,
  input wire logic        o_illegal_reset,
  input wire logic        o_ext_bus_en,
  input wire logic        o_irq
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  logic [7:0] stall_cnt_r;
  wire  [17:0] glb = {o_cpu_page, i_cpu_addr[13:0]};
  wire  hole = !(glb <= 18'h0_03FF || (glb >= 18'h0_4000 - RAM_SIZE && glb <= 18'h0_3FFF) ||
                 (glb >= 18'h0_4400 && glb <= 18'h0_53FF) ||
                 {1'b0, glb} >= 19'h4_0000 - FLASH_SIZE);
  wire  cpu_user = o_cpu_grant && !o_background_debug_mode;

  ////////////////////////////////////////////////////////////////////////////////
  // Saturates so that a very long stall never wraps back into the CPU-wins zone
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) stall_cnt_r <= 8'h00;
    else if (!i_dbg_req || o_dbg_grant) stall_cnt_r <= 8'h00;
    else if (stall_cnt_r != 8'hFF) stall_cnt_r <= stall_cnt_r + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////////
  grant_one_master_a: assert property (!(o_cpu_grant && o_dbg_grant))
    else $error("both masters granted");
  cpu_wins_tie_a: assert property (i_cpu_req && i_dbg_req && stall_cnt_r < 8'd128 |-> o_cpu_grant)
    else $error("cpu lost arbitration too early");
  dbg_starve_win_a: assert property (i_dbg_req && i_cpu_op_end && stall_cnt_r > 8'd129
    |-> ##[0:2] o_dbg_grant) else $error("starved debug master not granted");
  paged_window_a: assert property (cpu_user && i_cpu_addr[15:14] == 2'b10
    |=> o_tgt_addr == {$past(o_cpu_page), $past(i_cpu_addr[13:0])}) else $error("paged address wrong");
  top_unpaged_a: assert property (cpu_user && i_cpu_addr[15:14] == 2'b11
    |=> o_tgt_addr == {4'hF, $past(i_cpu_addr[13:0])} && o_tgt_sel == 3'h4)
    else $error("top window not fixed");
  illegal_access_a: assert property (cpu_user && i_cpu_addr[15:14] == 2'b10
    |=> o_illegal_reset == $past(hole)) else $error("illegal reset mismatch");
  dbg_no_reset_a: assert property (o_dbg_grant |=> !o_illegal_reset)
    else $error("debug access caused reset");
  no_irq_bus_a: assert property (o_irq == 1'b0 && o_ext_bus_en == 1'b0)
    else $error("interrupt or external bus active");
  debug_overlay_a: assert property (o_background_debug_mode && o_dbg_grant && i_dbg_cycle &&
    i_dbg_addr[15:8] == 8'hFF |=> o_tgt_sel == 3'h5) else $error("debug overlay not selected");

  cover property (o_dbg_grant && stall_cnt_r > 8'd129);
  cover property (o_illegal_reset);
  cover property (o_background_debug_mode && o_dbg_grant && i_dbg_cycle);
endmodule // mmc_chk

bind mcu_memory_map_controller mmc_chk #(.RAM_SIZE(RAM_SIZE), .FLASH_SIZE(FLASH_SIZE)) u_mmc_chk (
  .i_sys_clk(i_sys_clk),
  .i_rst_b(i_rst_b),
  .i_cpu_req(i_cpu_req),
  .i_cpu_op_end(i_cpu_op_end),
  .i_cpu_addr(i_cpu_addr),
  .i_dbg_req(i_dbg_req),
  .i_dbg_cycle(i_dbg_cycle),
  .i_dbg_addr(i_dbg_addr),
  .o_cpu_grant(o_cpu_grant),
  .o_dbg_grant(o_dbg_grant),
  .o_cpu_page(o_cpu_page),
  .o_tgt_addr(o_tgt_addr),
  .o_tgt_sel(o_tgt_sel),
  .o_background_debug_mode(o_background_debug_mode),
  .o_illegal_reset(o_illegal_reset),
  .o_ext_bus_en(o_ext_bus_en),
  .o_irq(o_irq)
);

`default_nettype wire

// *** tb_top.sv ***
// Testbench: paging, global decode, illegal access, arbitration, debug overlay
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        i_sys_clk, i_rst_b, i_operating_mode_select, i_debug_exit, i_reg_wr, i_reg_rd;
  logic [3:0]  i_reg_addr, i_cpu_page_wdata, o_cpu_page;
  logic [7:0]  i_reg_wdata, o_reg_rdata;
  logic        i_cpu_req, i_cpu_we, i_cpu_word, i_cpu_op_end, i_cpu_page_wr, o_cpu_grant;
  logic [15:0] i_cpu_addr, i_cpu_wdata, o_cpu_rdata, i_dbg_addr, i_dbg_wdata, o_dbg_rdata;
  logic [15:0] o_tgt_wdata, i_tgt_rdata;
  logic        i_dbg_req, i_dbg_we, i_dbg_cycle, i_dbg_page_en, i_dbg_cmd_uses_page, o_dbg_grant;
  logic [17:0] o_tgt_addr;
  logic [2:0]  o_tgt_sel;
  logic        o_tgt_we, o_tgt_word, o_background_debug_mode, o_special_mode;
  logic        o_illegal_reset, o_ext_bus_en, o_irq;
  int          err_count, comparisons, n;

  typedef struct packed {
    logic [3:0] pg; logic [15:0] a; logic w; logic [17:0] ta; logic [2:0] sel; logic ill;
  } row_t;
  row_t rows [18] = '{
    '{4'hE, 16'h8000, 1'b0, 18'h3_8000, 3'h4, 1'b0}, '{4'hE, 16'hC123, 1'b1, 18'h3_C123, 3'h4, 1'b0},
    '{4'hA, 16'h4010, 1'b0, 18'h3_4010, 3'h4, 1'b0}, '{4'h3, 16'h8000, 1'b0, 18'h0_C000, 3'h0, 1'b1},
    '{4'h0, 16'h8010, 1'b1, 18'h0_0010, 3'h1, 1'b0}, '{4'h0, 16'h83FF, 1'b0, 18'h0_03FF, 3'h1, 1'b0},
    '{4'h0, 16'h8400, 1'b0, 18'h0_0400, 3'h0, 1'b1}, '{4'h1, 16'h8400, 1'b0, 18'h0_4400, 3'h3, 1'b0},
    '{4'h1, 16'h93FF, 1'b1, 18'h0_53FF, 3'h3, 1'b0}, '{4'h1, 16'h9400, 1'b0, 18'h0_5400, 3'h0, 1'b1},
    '{4'h0, 16'hA800, 1'b0, 18'h0_2800, 3'h2, 1'b0}, '{4'h0, 16'hA7FF, 1'b0, 18'h0_27FF, 3'h0, 1'b1},
    '{4'h8, 16'h8000, 1'b0, 18'h2_0000, 3'h4, 1'b0}, '{4'h7, 16'hBFFF, 1'b0, 18'h1_FFFF, 3'h0, 1'b1},
    '{4'h5, 16'h0200, 1'b1, 18'h0_0200, 3'h1, 1'b0}, '{4'h0, 16'hBFFF, 1'b1, 18'h0_3FFF, 3'h2, 1'b0},
    '{4'h1, 16'h8000, 1'b0, 18'h0_4000, 3'h0, 1'b1},
    '{4'h0, 16'h1000, 1'b0, 18'h3_1000, 3'h4, 1'b0}};

  mcu_memory_map_controller u_mcu_memory_map_controller (.*);
  tgt_model u_tgt_model (.i_tgt_addr(o_tgt_addr), .o_tgt_rdata(i_tgt_rdata));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask

  task automatic results;
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
    #1 chk("reg_rdata", d, o_reg_rdata);
  endtask

  // A register write in the same cycle must lose against the far call page write
  task automatic far_wr(input logic [3:0] p);
    @(posedge i_sys_clk);
    i_cpu_page_wr <= 1'b1;
    i_cpu_page_wdata <= p;
    i_reg_wr <= 1'b1;
    i_reg_addr <= 4'h1;
    i_reg_wdata <= {4'h0, ~p};
    @(posedge i_sys_clk);
    i_cpu_page_wr <= 1'b0;
    i_reg_wr <= 1'b0;
    #1 chk("cpu_page", p, o_cpu_page);
  endtask

  task automatic acc(input logic dbg, input logic [15:0] a, input logic w, input logic [17:0] ta,
                     input logic [2:0] sel, input logic ill);
    int k;
    logic [15:0] rd;
    k = 0;
    @(posedge i_sys_clk);
    i_cpu_req <= !dbg;
    i_dbg_req <= dbg;
    i_cpu_addr <= a;
    i_dbg_addr <= a;
    i_cpu_we <= w;
    i_dbg_we <= w;
    i_cpu_word <= w;
    i_cpu_wdata <= ~a;
    i_dbg_wdata <= ~a;
    @(negedge i_sys_clk);
    while ((dbg ? o_dbg_grant : o_cpu_grant) !== 1'b1 && k < 300) begin
      @(negedge i_sys_clk);
      k++;
    end
    @(posedge i_sys_clk);
    i_cpu_req <= 1'b0;
    i_dbg_req <= 1'b0;
    #1 chk("tgt_addr", ta, o_tgt_addr);
    chk("tgt_sel", sel, o_tgt_sel);
    chk("tgt_we", w, o_tgt_we);
    chk("illegal_reset", ill, o_illegal_reset);
    chk("tgt_word", dbg | w, o_tgt_word);
    if (w) chk("tgt_wdata", 16'(~a), o_tgt_wdata);
    // The responder mixes the page bits into the data it returns
    if (!w) begin
      @(posedge i_sys_clk);
      #1 rd = ta[15:0] ^ {12'hA5A, ta[17:14]};
      if (dbg) chk("dbg_rdata", rd, o_dbg_rdata);
      else chk("cpu_rdata", a[0] ? rd[7:0] : rd[15:8], o_cpu_rdata);
    end
    // Leave room for a self-reset after an illegal access
    if (ill) repeat (8) @(posedge i_sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  initial begin
    #50000;
    err_count++;
    results();
  end

  initial begin
    {i_rst_b, i_debug_exit, i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = '0;
    {i_cpu_req, i_cpu_we, i_cpu_word, i_cpu_page_wr, i_cpu_page_wdata} = '0;
    {i_cpu_addr, i_cpu_wdata, i_dbg_addr, i_dbg_wdata} = '0;
    {i_dbg_req, i_dbg_we, i_dbg_cycle, i_dbg_page_en, i_dbg_cmd_uses_page} = '0;
    i_operating_mode_select = 1'b1;
    i_cpu_op_end = 1'b1;
    repeat (20) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    repeat (10) @(posedge i_sys_clk);
    #1 chk("cpu_page", 4'hE, o_cpu_page);
    chk("debug_mode", 1'b0, o_background_debug_mode);
    reg_rd(4'h1, 8'h0E);
    reg_rd(4'h2, 8'h00);
    reg_rd(4'hA, 8'h00);
    foreach (rows[i]) begin
      reg_wr(4'h1, {4'h0, rows[i].pg});
      acc(1'b0, rows[i].a, rows[i].w, rows[i].ta, rows[i].sel, rows[i].ill);
    end
    far_wr(4'h9);
    reg_rd(4'h1, 8'h09);
    acc(1'b0, 16'h8004, 1'b0, 18'h2_4004, 3'h4, 1'b0);
    acc(1'b0, 16'hFFFE, 1'b0, 18'h3_FFFE, 3'h4, 1'b0);
    far_wr(4'hE);
    // Starve the debug master while the CPU stays mid-operation
    @(posedge i_sys_clk);
    i_cpu_op_end <= 1'b0;
    {i_cpu_req, i_dbg_req, i_cpu_we, i_dbg_we} <= 4'b1100;
    i_cpu_addr <= 16'hC000;
    i_dbg_addr <= 16'hC010;
    repeat (140) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    chk("cpu_grant", 1'b1, o_cpu_grant);
    chk("dbg_grant", 1'b0, o_dbg_grant);
    @(posedge i_sys_clk);
    i_cpu_op_end <= 1'b1;
    n = 0;
    while (o_dbg_grant !== 1'b1 && n < 6) begin
      @(negedge i_sys_clk);
      n++;
    end
    chk("dbg_grant", 1'b1, o_dbg_grant);
    @(posedge i_sys_clk);
    {i_cpu_req, i_dbg_req} <= 2'b00;
    // Second reset in mid-run, this time into the special mode
    i_rst_b <= 1'b0;
    i_operating_mode_select <= 1'b0;
    repeat (5) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    repeat (12) @(posedge i_sys_clk);
    #1 chk("debug_mode", 1'b1, o_background_debug_mode);
    chk("special_mode", 1'b1, o_special_mode);
    reg_rd(4'h3, 8'h01);
    i_dbg_cycle <= 1'b1;
    acc(1'b1, 16'hFF10, 1'b0, 18'h3_FF10, 3'h5, 1'b0);
    reg_wr(4'h1, 8'h0F);
    acc(1'b1, 16'hBF20, 1'b0, 18'h3_FF20, 3'h5, 1'b0);
    i_dbg_cycle <= 1'b0;
    reg_wr(4'h2, 8'h05);
    reg_rd(4'h2, 8'h05);
    {i_dbg_page_en, i_dbg_cmd_uses_page} <= 2'b11;
    acc(1'b1, 16'h8000, 1'b1, 18'h1_4000, 3'h0, 1'b0);
    i_dbg_cmd_uses_page <= 1'b0;
    acc(1'b1, 16'h8008, 1'b0, 18'h3_C008, 3'h4, 1'b0);
    @(posedge i_sys_clk);
    i_debug_exit <= 1'b1;
    @(posedge i_sys_clk);
    i_debug_exit <= 1'b0;
    #1 chk("debug_mode", 1'b0, o_background_debug_mode);
    results();
  end
endmodule // tb_top

`default_nettype wire
